// [hw/issue_model_defines.svh]
// Purpose: Timing counts, widths and reset values for the issue latency model
// Assumes: Counts are in core clock cycles at clk_sys
// Notes: Included by the package and by the design files
`ifndef ISSUE_MODEL_DEFINES_SVH
`define ISSUE_MODEL_DEFINES_SVH

// Field widths and wake slot count
`define LAT_W 4
`define REP_W 3
`define CNT_W 3
`define INFL_W 4
`define SLOT_N 9

// Result latencies in cycles
`define LAT_NONE 4'h0
`define LAT_ALU 4'h1
`define LAT_LOAD_WIDE 4'h4
`define LAT_LOAD_NARROW 4'h5
`define LAT_RMW 4'h5
`define LAT_MUL_REG 4'h4
`define LAT_MUL_REG64 4'h6
`define LAT_MUL_MEM 4'h8
`define LAT_MUL_MEM64 4'hA
`define LAT_POPCNT 4'h4
`define LAT_POPCNT_MEM64 4'hA

// Smallest latency that goes through the wake slots
`define LAT_SLOT_BASE 4'h2

// Multiply repeat intervals in cycles
`define REP_MUL 3'h2
`define REP_MUL64 3'h4

// Reset values
`define CNT_RST 3'h0
`define REP_RST 3'h0
`define INFL_RST 4'h0

`endif

// [hw/issue_model_pkg.sv]
// Purpose: Types shared by the issue latency model and its class table
// Assumes: Constants come from the defines header
// Notes: Form codes are the decoder's compact encoding of instruction forms
`include "issue_model_defines.svh"

package issue_model_pkg;

	// Instruction forms handled by this slice
	typedef enum logic [5:0] {
		mov_reg_mem8 = 6'h00, mov_reg_mem16 = 6'h01, mov_reg_mem32 = 6'h02,
		mov_reg_mem64 = 6'h03, mov_mem_reg = 6'h04, mov_mem_imm = 6'h05,
		mov_seg_mem = 6'h06, mov_seg_reg = 6'h07, store_nontemporal = 6'h08,
		string_move = 6'h09, movsx_reg = 6'h0A, movsx_mem = 6'h0B,
		movsxd_reg = 6'h0C, movsxd_mem = 6'h0D, movzx_reg = 6'h0E,
		movzx_mem = 6'h0F, mul_reg8 = 6'h10, mul_reg16 = 6'h11,
		mul_reg32 = 6'h12, mul_reg64 = 6'h13, mul_mem8 = 6'h14,
		mul_mem16 = 6'h15, mul_mem32 = 6'h16, mul_mem64 = 6'h17,
		neg_reg = 6'h18, neg_mem = 6'h19, no_op = 6'h1A,
		not_reg = 6'h1B, not_mem = 6'h1C, or_reg_reg = 6'h1D,
		or_reg_imm = 6'h1E, or_mem_reg = 6'h1F, or_mem_imm = 6'h20,
		or_reg_mem = 6'h21, pop_reg16 = 6'h22, pop_reg32 = 6'h23,
		pop_reg64 = 6'h24, pop_mem = 6'h25, pop_seg = 6'h26,
		pop_all = 6'h27, popcnt_reg = 6'h28, popcnt_mem16 = 6'h29,
		popcnt_mem32 = 6'h2A, popcnt_mem64 = 6'h2B, pop_flags = 6'h2C,
		push_reg = 6'h2D, push_imm = 6'h2E, push_mem = 6'h2F,
		push_seg = 6'h30, push_all = 6'h31, push_flags = 6'h32,
		rotate_reg = 6'h33, rotate_mem = 6'h34, ret_near = 6'h35,
		ret_near_imm = 6'h36
	} form_type;

	// How the decoder hands a form on
	typedef enum logic [1:0] {
		fast_decode_one_op = 2'b00,
		fast_decode_two_ops = 2'b01,
		microcode_seq = 2'b10,
		decode_unknown = 2'b11
	} decode_type;

	// One line of the class table
	typedef struct packed {
		decode_type decode;
		logic integer_pipe_a;
		logic integer_pipe_b;
		logic [`LAT_W-1:0] latency;
		logic fixed;
	} class_entry_type;

endpackage

// [hw/class_table.sv]
// Purpose: Class table giving decode kind, pipes and latency per form
// Assumes: Read every cycle; data appear one edge after the address
// Notes: Codes outside the slice read as unknown with no fixed latency
`timescale 1ns/10ps
`default_nettype none
`include "issue_model_defines.svh"

module class_table (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Lookup
	input wire issue_model_pkg::form_type addr,
	output issue_model_pkg::class_entry_type rdata_q
);
	import issue_model_pkg::*;

	// Builds one table line
	function automatic class_entry_type ent(decode_type d, logic pa, logic pb,
		logic [`LAT_W-1:0] lat, logic fx);
		class_entry_type e;
		e.decode = d;
		e.integer_pipe_a = pa;
		e.integer_pipe_b = pb;
		e.latency = lat;
		e.fixed = fx;
		return e;
	endfunction

	class_entry_type rdata_d;

	// Table contents
	always_comb begin
		case (addr)
			mul_reg8, mul_reg16, mul_reg32: rdata_d = ent(fast_decode_one_op, 1'b0, 1'b1, `LAT_MUL_REG, 1'b1);
			mul_reg64: rdata_d = ent(fast_decode_one_op, 1'b0, 1'b1, `LAT_MUL_REG64, 1'b1);
			mul_mem8, mul_mem16, mul_mem32: rdata_d = ent(fast_decode_one_op, 1'b0, 1'b1, `LAT_MUL_MEM, 1'b1);
			mul_mem64: rdata_d = ent(fast_decode_one_op, 1'b0, 1'b1, `LAT_MUL_MEM64, 1'b1);
			no_op: rdata_d = ent(fast_decode_one_op, 1'b0, 1'b0, `LAT_NONE, 1'b1);
			neg_reg, not_reg, or_reg_reg, or_reg_imm: rdata_d = ent(fast_decode_one_op, 1'b1, 1'b1, `LAT_ALU, 1'b1);
			neg_mem, not_mem, or_mem_reg, or_mem_imm, or_reg_mem: rdata_d = ent(fast_decode_one_op, 1'b1, 1'b1, `LAT_RMW, 1'b1);
			mov_reg_mem8, mov_reg_mem16: rdata_d = ent(fast_decode_one_op, 1'b1, 1'b1, `LAT_LOAD_NARROW, 1'b1);
			mov_reg_mem32, mov_reg_mem64, mov_mem_reg, mov_mem_imm, movzx_mem: rdata_d = ent(fast_decode_one_op, 1'b1, 1'b1, `LAT_LOAD_WIDE, 1'b1);
			mov_seg_mem, mov_seg_reg: rdata_d = ent(microcode_seq, 1'b0, 1'b0, `LAT_NONE, 1'b0);
			string_move, pop_seg, pop_all, pop_flags, push_all, push_flags: rdata_d = ent(microcode_seq, 1'b0, 1'b0, `LAT_NONE, 1'b0);
			pop_reg16, pop_mem, push_mem, push_seg: rdata_d = ent(fast_decode_two_ops, 1'b1, 1'b1, `LAT_ALU, 1'b1);
			pop_reg32, pop_reg64, push_reg, push_imm: rdata_d = ent(fast_decode_one_op, 1'b1, 1'b1, `LAT_ALU, 1'b1);
			popcnt_reg, popcnt_mem16, popcnt_mem32: rdata_d = ent(fast_decode_one_op, 1'b1, 1'b1, `LAT_POPCNT, 1'b1);
			popcnt_mem64: rdata_d = ent(fast_decode_one_op, 1'b1, 1'b1, `LAT_POPCNT_MEM64, 1'b1);
			ret_near: rdata_d = ent(fast_decode_one_op, 1'b1, 1'b1, `LAT_ALU, 1'b1);
			ret_near_imm: rdata_d = ent(microcode_seq, 1'b1, 1'b1, `LAT_NONE, 1'b0);
			rotate_reg: rdata_d = ent(fast_decode_one_op, 1'b1, 1'b1, `LAT_ALU, 1'b1);
			rotate_mem: rdata_d = ent(fast_decode_one_op, 1'b1, 1'b1, `LAT_RMW, 1'b1);
			store_nontemporal: rdata_d = ent(fast_decode_one_op, 1'b1, 1'b1, `LAT_ALU, 1'b1);
			movsx_reg, movsxd_reg, movzx_reg: rdata_d = ent(fast_decode_one_op, 1'b1, 1'b1, `LAT_ALU, 1'b1);
			movsx_mem, movsxd_mem: rdata_d = ent(fast_decode_one_op, 1'b1, 1'b1, `LAT_RMW, 1'b1);
			default: rdata_d = ent(decode_unknown, 1'b0, 1'b0, `LAT_NONE, 1'b0);
		endcase
	end

	// Registered read port
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

endmodule
`default_nettype wire

// [hw/integer_issue_latency_model.sv]
// Purpose: Classifies integer instruction forms and times their results
// Assumes: One request per cycle from the decoder; issue is the cycle after take
// Notes: Multiplies are refused while the second pipe's repeat interval runs
`timescale 1ns/10ps
`default_nettype none
`include "issue_model_defines.svh"

module integer_issue_latency_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Request from the decoder
	input wire logic req_valid,
	input wire issue_model_pkg::form_type req_form,
	// Classification toward the scheduler
	output logic cls_valid_q,
	output issue_model_pkg::form_type cls_form_q,
	output issue_model_pkg::decode_type cls_decode,
	output logic cls_pipe_a,
	output logic cls_pipe_b,
	output logic [`LAT_W-1:0] cls_latency,
	output logic cls_fixed,
	output logic [`REP_W-1:0] cls_repeat_q,
	// Refusal and multiply blocking
	output logic refused_q,
	output logic mul_block_q,
	// Result wake-up
	output logic [`CNT_W-1:0] wake_count_q,
	output logic [`INFL_W-1:0] inflight_q
);
	import issue_model_pkg::*;

	// True for every multiply form
	function automatic logic is_mul(form_type f);
		return (f >= mul_reg8) && (f <= mul_mem64);
	endfunction

	// Repeat interval of a multiply form, zero for others
	function automatic logic [`REP_W-1:0] mul_repeat(form_type f);
		if (!is_mul(f)) begin
			return `REP_RST;
		end
		if ((f == mul_reg64) || (f == mul_mem64)) begin
			return `REP_MUL64;
		end
		return `REP_MUL;
	endfunction

	class_entry_type entry_q;
	logic take;
	logic req_mul;
	logic [`REP_W-1:0] mul_cnt_q;
	logic [`REP_W-1:0] mul_cnt_d;
	logic timed_issue;
	logic direct_wake;
	logic [`LAT_W-1:0] slot_index;
	logic [`CNT_W-1:0] slot_q [`SLOT_N];
	logic [`CNT_W-1:0] slot_d [`SLOT_N];
	logic [`CNT_W-1:0] wake_count_d;
	logic [`INFL_W-1:0] inflight_d;

	// Class table lookup, data valid one edge after the request
	class_table u_table (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.addr(req_form),
		.rdata_q(entry_q)
	);

	// Classification fields straight from the table register
	assign cls_decode = entry_q.decode;
	assign cls_pipe_a = entry_q.integer_pipe_a;
	assign cls_pipe_b = entry_q.integer_pipe_b;
	assign cls_latency = entry_q.latency;
	assign cls_fixed = entry_q.fixed;

	// A multiply is refused while the second pipe is still busy
	assign req_mul = is_mul(req_form);
	assign take = req_valid && !(req_mul && mul_block_q);

	// Repeat interval countdown, counted from the taking edge
	assign mul_cnt_d = (take && req_mul) ? mul_repeat(req_form) - `REP_W'(1) :
		((mul_cnt_q != `REP_RST) ? mul_cnt_q - `REP_W'(1) : `REP_RST);

	// Issue decode for the result timer
	assign timed_issue = cls_valid_q && cls_fixed && (cls_latency != `LAT_NONE);
	assign direct_wake = timed_issue && (cls_latency == `LAT_ALU);
	assign slot_index = cls_latency - `LAT_SLOT_BASE;

	// Wake slots shift toward slot 0; a new issue lands at latency minus two
	genvar gi;
	generate
		for (gi = 0; gi < `SLOT_N; gi++) begin : g_slot
			logic [`CNT_W-1:0] upper;
			logic hit;
			assign upper = (gi == `SLOT_N - 1) ? `CNT_RST : slot_q[(gi + 1) % `SLOT_N];
			assign hit = timed_issue && !direct_wake && (slot_index == `LAT_W'(gi));
			assign slot_d[gi] = upper + {{(`CNT_W - 1){1'b0}}, hit};
		end
	endgenerate

	// Results becoming ready in the next cycle
	assign wake_count_d = slot_q[0] + {{(`CNT_W - 1){1'b0}}, direct_wake};

	// Operations with a timed result still outstanding
	assign inflight_d = inflight_q + {{(`INFL_W - 1){1'b0}}, timed_issue}
		- `INFL_W'(wake_count_q);

	// Request side registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cls_valid_q <= 1'b0;
			cls_form_q <= mov_reg_mem8;
			cls_repeat_q <= `REP_RST;
			refused_q <= 1'b0;
			mul_cnt_q <= `REP_RST;
			mul_block_q <= 1'b0;
		end else begin
			cls_valid_q <= take;
			cls_form_q <= req_form;
			cls_repeat_q <= mul_repeat(req_form);
			refused_q <= req_valid && !take;
			mul_cnt_q <= mul_cnt_d;
			mul_block_q <= (mul_cnt_d != `REP_RST);
		end
	end

	// Result timer registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `SLOT_N; i++) begin
				slot_q[i] <= `CNT_RST;
			end
			wake_count_q <= `CNT_RST;
			inflight_q <= `INFL_RST;
		end else begin
			for (int i = 0; i < `SLOT_N; i++) begin
				slot_q[i] <= slot_d[i];
			end
			wake_count_q <= wake_count_d;
			inflight_q <= inflight_d;
		end
	end

	// Register multiplies of 32 bits or less sit on pipe b only
	property p_mul_reg_class;
		@(posedge clk_sys) disable iff (!rst_n)
		cls_valid_q && ((cls_form_q == mul_reg8) || (cls_form_q == mul_reg32)) |->
			!cls_pipe_a && cls_pipe_b && (cls_decode == fast_decode_one_op)
			&& (cls_latency == 4'h4) && (cls_repeat_q == 3'h2);
	endproperty
	a_mul_reg_class: assert property (p_mul_reg_class)
		else $error("narrow register multiply misclassified");

	// A 64-bit register multiply blocks pipe b for three further cycles
	property p_mul64_block;
		@(posedge clk_sys) disable iff (!rst_n)
		req_valid && (req_form == mul_reg64) && !mul_block_q |=>
			mul_block_q [*3] ##1 !mul_block_q;
	endproperty
	a_mul64_block: assert property (p_mul64_block)
		else $error("64-bit multiply repeat interval wrong");

	// A narrow memory multiply is ready eight cycles after issue
	property p_mul_mem_wake;
		@(posedge clk_sys) disable iff (!rst_n)
		cls_valid_q && (cls_form_q == mul_mem16) |->
			(cls_latency == 4'h8) ##8 (wake_count_q != 3'h0);
	endproperty
	a_mul_mem_wake: assert property (p_mul_mem_wake)
		else $error("memory multiply result not woken at 8");

	// A narrow memory multiply frees the pipe after two cycles
	property p_mul_mem_block;
		@(posedge clk_sys) disable iff (!rst_n)
		req_valid && (req_form == mul_mem8) && !mul_block_q |=>
			mul_block_q ##1 !mul_block_q;
	endproperty
	a_mul_mem_block: assert property (p_mul_mem_block)
		else $error("memory multiply repeat interval wrong");

	// A 64-bit memory multiply takes ten cycles and repeats after four
	property p_mul_mem64;
		@(posedge clk_sys) disable iff (!rst_n)
		cls_valid_q && (cls_form_q == mul_mem64) |->
			(cls_latency == 4'hA) && (cls_repeat_q == 3'h4) && cls_pipe_b && !cls_pipe_a;
	endproperty
	a_mul_mem64: assert property (p_mul_mem64)
		else $error("64-bit memory multiply misclassified");

	// A no-op touches no pipe and never raises a wake-up
	property p_no_op;
		@(posedge clk_sys) disable iff (!rst_n)
		cls_valid_q && (cls_form_q == no_op) |->
			!cls_pipe_a && !cls_pipe_b && (cls_latency == 4'h0)
			&& (cls_decode == fast_decode_one_op) && (inflight_d == inflight_q - 4'(wake_count_q));
	endproperty
	a_no_op: assert property (p_no_op)
		else $error("no-op mapped to resources");

	// Register logic forms wake one cycle after issue on either pipe
	property p_logic_reg;
		@(posedge clk_sys) disable iff (!rst_n)
		cls_valid_q && (cls_form_q == or_reg_reg) |->
			cls_pipe_a && cls_pipe_b ##1 (wake_count_q != 3'h0);
	endproperty
	a_logic_reg: assert property (p_logic_reg)
		else $error("register logic form not ready after 1");

	// Memory destination logic forms wake five cycles after issue
	property p_logic_mem;
		@(posedge clk_sys) disable iff (!rst_n)
		cls_valid_q && (cls_form_q == not_mem) |->
			(cls_latency == 4'h5) ##5 (wake_count_q != 3'h0);
	endproperty
	a_logic_mem: assert property (p_logic_mem)
		else $error("memory logic form not ready after 5");

	// Narrow and wide loads
	property p_loads;
		@(posedge clk_sys) disable iff (!rst_n)
		cls_valid_q |->
			((cls_form_q == mov_reg_mem8) -> (cls_latency == 4'h5))
			&& ((cls_form_q == mov_mem_imm) -> (cls_latency == 4'h4))
			&& ((cls_form_q == movzx_mem) -> (cls_latency == 4'h4));
	endproperty
	a_loads: assert property (p_loads)
		else $error("load latency wrong");

	// Segment and string forms except push_seg go to the sequencer with no fixed latency
	property p_microcode;
		@(posedge clk_sys) disable iff (!rst_n)
		cls_valid_q && ((cls_form_q == mov_seg_reg) || (cls_form_q == pop_flags)
			|| (cls_form_q == string_move)) |->
			(cls_decode == microcode_seq) && !cls_fixed ##1 (inflight_q == $past(inflight_q)
			- 4'($past(wake_count_q)));
	endproperty
	a_microcode: assert property (p_microcode)
		else $error("microcode form timed or fast-decoded");

	// Stack forms decode as two operations where required
	property p_stack;
		@(posedge clk_sys) disable iff (!rst_n)
		cls_valid_q && (cls_form_q == pop_reg16 || cls_form_q == push_seg) |->
			(cls_decode == fast_decode_two_ops) && (cls_latency == 4'h1);
	endproperty
	a_stack: assert property (p_stack)
		else $error("stack form decode count wrong");

	// Population count from 64-bit memory wakes after ten cycles
	property p_popcnt64;
		@(posedge clk_sys) disable iff (!rst_n)
		cls_valid_q && (cls_form_q == popcnt_mem64) |->
			##10 (wake_count_q != 3'h0);
	endproperty
	a_popcnt64: assert property (p_popcnt64)
		else $error("population count result late or early");

	// A return releasing stack bytes is not fast-decoded
	property p_ret_imm;
		@(posedge clk_sys) disable iff (!rst_n)
		cls_valid_q && (cls_form_q == ret_near_imm) |-> (cls_decode == microcode_seq);
	endproperty
	a_ret_imm: assert property (p_ret_imm)
		else $error("return with count fast-decoded");

	// Rotates and sign extensions from memory take five cycles
	property p_mem_five;
		@(posedge clk_sys) disable iff (!rst_n)
		cls_valid_q && ((cls_form_q == rotate_mem) || (cls_form_q == movsxd_mem)) |->
			(cls_latency == 4'h5) && (cls_decode == fast_decode_one_op);
	endproperty
	a_mem_five: assert property (p_mem_five)
		else $error("memory rotate or sign extend latency wrong");

	// A non-temporal store is one op of one cycle
	property p_store_nt;
		@(posedge clk_sys) disable iff (!rst_n)
		cls_valid_q && (cls_form_q == store_nontemporal) |->
			(cls_latency == 4'h1) && cls_pipe_a && cls_pipe_b;
	endproperty
	a_store_nt: assert property (p_store_nt)
		else $error("non-temporal store misclassified");

	// A multiply during the repeat interval is refused, not classified
	property p_refuse;
		@(posedge clk_sys) disable iff (!rst_n)
		req_valid && is_mul(req_form) && mul_block_q |=> refused_q && !cls_valid_q;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("multiply taken while pipe b blocked");

endmodule
`default_nettype wire

// [tb/sched_model.sv]
// Purpose: Scheduler-side model that tallies timed issues and result wake-ups
// Assumes: Sees the classification and wake outputs every core clock
// Notes: Totals clear on reset, as the in-flight results are dropped then
`timescale 1ns/10ps
`default_nettype none
`include "issue_model_defines.svh"

module sched_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Issue and wake from the model
	input wire logic cls_valid_q,
	input wire logic cls_fixed,
	input wire logic [`LAT_W-1:0] cls_latency,
	input wire logic [`CNT_W-1:0] wake_count_q,
	// Totals seen by the scheduler
	output var int timed_issued,
	output var int woken
);
	// Count timed issues and the results that come back for them
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			timed_issued <= 0;
			woken <= 0;
		end else begin
			if (cls_valid_q && cls_fixed && cls_latency != 4'h0) begin
				timed_issued <= timed_issued + 1;
			end
			woken <= woken + int'(wake_count_q);
		end
	end
endmodule
`default_nettype wire

// [tb/integer_issue_latency_model_tb.sv]
// Purpose: Self-checking bench for the issue latency model
// Assumes: Inputs change at the falling edge; outputs are sampled there too
// Notes: Expected classes come from a table kept here, not from the design
`timescale 1ns/10ps
`default_nettype none
`include "issue_model_defines.svh"

module integer_issue_latency_model_tb;
	import issue_model_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	form_type req_form = mov_reg_mem8;
	logic cls_valid_q, cls_pipe_a, cls_pipe_b, cls_fixed, refused_q, mul_block_q;
	form_type cls_form_q;
	decode_type cls_decode;
	logic [`LAT_W-1:0] cls_latency;
	logic [`REP_W-1:0] cls_repeat_q;
	logic [`CNT_W-1:0] wake_count_q;
	logic [`INFL_W-1:0] inflight_q;
	int failures = 0;
	int comparisons = 0;
	int exp_wakes = 0;
	int timed_issued, woken;

	// Core clock, 20 ns period
	always #10 clk_sys = ~clk_sys;

	integer_issue_latency_model u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.req_valid(req_valid), .req_form(req_form), .cls_valid_q(cls_valid_q),
		.cls_form_q(cls_form_q), .cls_decode(cls_decode), .cls_pipe_a(cls_pipe_a),
		.cls_pipe_b(cls_pipe_b), .cls_latency(cls_latency), .cls_fixed(cls_fixed),
		.cls_repeat_q(cls_repeat_q), .refused_q(refused_q), .mul_block_q(mul_block_q),
		.wake_count_q(wake_count_q), .inflight_q(inflight_q));

	sched_model u_sched (.clk_sys(clk_sys), .rst_n(rst_n), .cls_valid_q(cls_valid_q),
		.cls_fixed(cls_fixed), .cls_latency(cls_latency), .wake_count_q(wake_count_q),
		.timed_issued(timed_issued), .woken(woken));

	// Expected {decode, pipe a, pipe b, latency, fixed, repeat} for a form code
	function automatic logic [11:0] expect_of(input logic [5:0] c);
		logic [1:0] d;
		logic pa, pb;
		logic [3:0] l;
		logic [2:0] r;
		d = 2'b00;
		pa = 1'b1;
		pb = 1'b1;
		l = 4'h1;
		r = 3'h0;
		case (c)
			6'h00, 6'h01, 6'h0B, 6'h0D: l = 4'h5;
			6'h19, 6'h1C, 6'h1F, 6'h20, 6'h21: l = 4'h5;
			6'h34: l = 4'h5;
			6'h02, 6'h03, 6'h04, 6'h05, 6'h0F: l = 4'h4;
			6'h28, 6'h29, 6'h2A: l = 4'h4;
			6'h2B: l = 4'hA;
			6'h22, 6'h25, 6'h2F, 6'h30: d = 2'b01;
			6'h06, 6'h07, 6'h09, 6'h26, 6'h27, 6'h2C, 6'h31, 6'h32: begin
				d = 2'b10;
				{pa, pb, l} = 6'h00;
			end
			6'h36: begin
				d = 2'b10;
				l = 4'h0;
			end
			6'h1A: {pa, pb, l} = 6'h00;
			6'h10, 6'h11, 6'h12: {pa, l, r} = {1'b0, 4'h4, 3'h2};
			6'h13: {pa, l, r} = {1'b0, 4'h6, 3'h4};
			6'h14, 6'h15, 6'h16: {pa, l, r} = {1'b0, 4'h8, 3'h2};
			6'h17: {pa, l, r} = {1'b0, 4'hA, 3'h4};
			default: begin
				if (c > 6'h36) begin
					d = 2'b11;
					{pa, pb, l} = 6'h00;
				end
			end
		endcase
		return {d, pa, pb, l, !d[1], r};
	endfunction

	// Report a mismatch and count every comparison
	task automatic compare(input logic [11:0] seen, input logic [11:0] want);
		comparisons++;
		if (seen !== want) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, want);
		end
	endtask

	// Print the verdict and stop
	task automatic test_done;
		if (failures == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Offer one form alone, check its class and when its result wakes
	task automatic class_one(input logic [5:0] c);
		logic [11:0] e;
		logic timed;
		e = expect_of(c);
		timed = e[3] && (e[7:4] != 4'h0);
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_form = form_type'(c);
		@(negedge clk_sys);
		req_valid = 1'b0;
		compare(12'({cls_valid_q, refused_q, cls_form_q}), 12'({2'b10, c}));
		compare({cls_decode, cls_pipe_a, cls_pipe_b, cls_latency, cls_fixed, cls_repeat_q}, e);
		if (timed) exp_wakes++;
		for (int j = 1; j <= 11; j++) begin
			@(negedge clk_sys);
			compare(12'(wake_count_q), 12'(timed && j == e[7:4]));
			if (j == 1) compare(12'(inflight_q), 12'(timed));
		end
		compare(12'(inflight_q), 12'h0);
	endtask

	// Multiply then a held narrow multiply: refused until the repeat runs out
	task automatic mul_spacing(input logic [5:0] c, input int rep);
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_form = form_type'(c);
		@(negedge clk_sys);
		req_form = mul_reg8;
		for (int k = 1; k <= rep; k++) begin
			if (k > 1) @(negedge clk_sys);
			compare(12'({cls_valid_q, refused_q, mul_block_q}), 12'({k == 1, k > 1, k < rep}));
		end
		@(negedge clk_sys);
		req_valid = 1'b0;
		compare(12'({cls_valid_q, refused_q, cls_repeat_q}), 12'({2'b10, 3'h2}));
		exp_wakes += 2;
		repeat (14) @(negedge clk_sys);
	endtask

	// A non-multiply goes through while the second pipe is blocked
	task automatic blocked_alu;
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_form = mul_reg64;
		@(negedge clk_sys);
		req_form = or_reg_reg;
		@(negedge clk_sys);
		req_valid = 1'b0;
		compare(12'({cls_valid_q, refused_q, mul_block_q, cls_latency}), 12'h51);
		exp_wakes += 2;
		repeat (10) @(negedge clk_sys);
	endtask

	// Two results due in the same cycle add up
	task automatic coincide;
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_form = rotate_mem;
		@(negedge clk_sys);
		req_form = mov_reg_mem32;
		@(negedge clk_sys);
		req_valid = 1'b0;
		compare(12'(inflight_q), 12'h1);
		@(negedge clk_sys);
		compare(12'(inflight_q), 12'h2);
		repeat (3) @(negedge clk_sys);
		compare(12'(wake_count_q), 12'h2);
		exp_wakes += 2;
		repeat (6) @(negedge clk_sys);
	endtask

	// Reset in mid-flight drops results and clears the multiply block
	task automatic mid_reset;
		// Every timed issue so far has come back before the reset drops the totals
		compare(12'(woken), 12'(exp_wakes));
		compare(12'(timed_issued), 12'(exp_wakes));
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_form = mul_mem64;
		@(negedge clk_sys);
		req_valid = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b0;
		#1;
		compare(12'({cls_valid_q, refused_q, mul_block_q, inflight_q, wake_count_q}), 12'h0);
		exp_wakes = 0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		req_valid = 1'b1;
		req_form = mul_reg64;
		@(negedge clk_sys);
		req_valid = 1'b0;
		compare(12'({cls_valid_q, cls_latency, cls_repeat_q}), 12'({1'b1, 4'h6, 3'h4}));
		exp_wakes = 1;
		for (int j = 1; j <= 12; j++) begin
			@(negedge clk_sys);
			compare(12'(wake_count_q), 12'(j == 6));
		end
	endtask

	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge clk_sys);
		failures++;
		$display("[ERR] %0t run did not finish", $time);
		test_done();
	end

	// Main sequence
	initial begin
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		for (int i = 0; i <= 8'h37; i++) class_one(6'(i));
		mul_spacing(6'h12, 2);
		mul_spacing(6'h13, 4);
		mul_spacing(6'h14, 2);
		mul_spacing(6'h17, 4);
		blocked_alu();
		coincide();
		mid_reset();
		compare(12'(woken), 12'(exp_wakes));
		compare(12'(timed_issued), 12'(exp_wakes));
		test_done();
	end
endmodule
`default_nettype wire
